// file: imt_pkg.sv
// Constants, register layout and types for the bus master transmitter.
// Assumes a single 100 MHz system clock and an open-drain SCL/SDA pair.
// How it works
// - Own-address recognition on the bus is active while format_select is 0.
// - With bit_order_select 0 each byte leaves most significant bit first.
// - With pause_insert 0 the acknowledge bit follows the eighth bit directly.
// - With reply_check_off 0 a ninth clock samples the receiver's acknowledge.
// - As master the block drives SCL and SDA; the slave acknowledges bytes.
// - peripheral_clock_halve picks the full or halved system clock for timing.
// - register_window_select 1 maps the bus registers onto the shared addresses.
// - own_address_reg keeps seven address bits above the format_select bit.
// - Own address must be valid since slave operation can occur in master use.
// - bus_unit_enable 1 turns the shared address from own address to mode_reg.
// - Arbitration loss drops master and transmit selects, going to slave receive.
// - bus_busy_flag reads 0 on a free bus; software waits for it first.
// - A start pulls SDA low while SCL stays high.
// - Writing data_shift_reg starts a byte; first byte is address with write bit.
// - After the data write SCL pulses go out with the shift register bits.
// - On the ninth clock done is set, acknowledge recorded and SCL held low.
// - Done flag and transfer_irq_enable both 1 raise the interrupt request.
// - Busy and gate both written 0 produce a stop: SDA rises with SCL high.

package imt_pkg;

  // Clock and bit timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned QTR_CYCLES_DEF = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_SHARED = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_BUS = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_SYS = 3'h4;

  // Bit positions in the control register.
  localparam int CTRL_BUE = 7;
  localparam int CTRL_IE = 6;
  localparam int CTRL_REPLY = 3;
  localparam int CTRL_HIT = 2;

  // Bit positions in the bus command and status register.
  localparam int BUS_BUSY = 7;
  localparam int BUS_GATE = 6;
  localparam int BUS_MS = 5;
  localparam int BUS_TS = 4;
  localparam int BUS_ARB = 1;
  localparam int BUS_DONE = 0;

  // Bit positions in the system register.
  localparam int SYS_HALVE = 0;
  localparam int SYS_WIN = 1;

  // Reset values.
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Own address layout.
  typedef struct packed {
    logic [6:0] slave_addr;
    logic format_select;
  } imt_own_addr_t;

  // Mode register layout.
  typedef struct packed {
    logic bit_order_select;
    logic pause_insert;
    logic reply_check_off;
    logic clock_rate_ext;
    logic spare;
    logic [2:0] clock_rate_sel;
  } imt_mode_t;

  // Quarter-bit phases of one SCL period.
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_HOLD = 3'h2,
    ST_BIT = 3'h3,
    ST_PAUSE = 3'h4,
    ST_ACK = 3'h5,
    ST_STOP = 3'h6
  } imt_state_t;

endpackage

// file: imt_master_tx.sv
// Bus master transmitter with a plain register port and open-drain pins.
// Assumes pin inputs already synchronous to clk_sys and external pull-ups.
`timescale 1ns/1ps
`default_nettype none

module imt_master_tx
  import imt_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = QTR_CYCLES_DEF
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Open-drain clock line.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Open-drain data line.
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt request.
  output logic irq_req
);

  // The quarter length is shifted up to eight places into 16 bits.
  if (QTR_CYCLES < 1 || QTR_CYCLES > 255) begin : g_bad_qtr
    $error("QTR_CYCLES must lie between 1 and 255");
  end

  imt_state_t st;
  logic [1:0] ph;
  logic [2:0] bit_idx;
  imt_own_addr_t own_address_reg;
  imt_mode_t mode_reg;
  logic [7:0] data_shift_reg;
  logic bus_unit_enable, transfer_irq_enable, slave_reply_bit, own_hit;
  logic bus_busy_flag, master_select, transmit_select;
  logic arb_lost, transfer_done_flag;
  logic peripheral_clock_halve, register_window_select;
  logic ev_done, ev_ack, ack_val, ev_arb;
  logic half_tgl, tick, run, stretch, qdone;
  logic [15:0] qcnt, qlen, qlen_m1;
  logic scl_q, sda_q, start_seen, stop_seen, scl_rise;
  logic snif_act, hit_ev;
  logic [2:0] snif_cnt;
  logic [6:0] snif_sh;
  logic wr_shared, wr_ctrl, wr_bus, wr_data, wr_sys;
  logic start_req, stop_req;
  logic [7:0] rd_mux;

  // Picks the outgoing bit for an index under the selected bit order.
  function automatic logic pick_bit(input logic [2:0] idx);
    pick_bit = mode_reg.bit_order_select ? data_shift_reg[idx]
                                         : data_shift_reg[3'h7 - idx];
  endfunction

  // Write decode; bus registers hide while the window is closed.
  assign wr_shared = reg_wr && reg_addr == ADDR_SHARED
                     && register_window_select;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL && register_window_select;
  assign wr_bus = reg_wr && reg_addr == ADDR_BUS && register_window_select;
  assign wr_data = reg_wr && reg_addr == ADDR_DATA && register_window_select;
  assign wr_sys = reg_wr && reg_addr == ADDR_SYS;

  // A start needs busy, master and transmit set with gate clear in one write, so no stray start occurs.
  assign start_req = wr_bus && reg_wdata[BUS_BUSY] && !reg_wdata[BUS_GATE]
                     && reg_wdata[BUS_MS] && reg_wdata[BUS_TS];
  assign stop_req = wr_bus && !reg_wdata[BUS_BUSY]
                    && !reg_wdata[BUS_GATE];

  // Timing tick: every cycle, or every other cycle when halved.
  assign tick = !peripheral_clock_halve || half_tgl;
  assign qlen = (16'(QTR_CYCLES) << mode_reg.clock_rate_sel)
                << mode_reg.clock_rate_ext;
  assign qlen_m1 = qlen - 16'h0001;
  assign run = st != ST_IDLE && st != ST_HOLD;
  // A slow or held SCL stretches the rise phase before timing resumes.
  assign stretch = ph == PH_RISE && !scl_in
                   && (st == ST_BIT || st == ST_ACK || st == ST_STOP);
  assign qdone = run && tick && !stretch && qcnt == qlen_m1;

  // Bus conditions observed on the lines.
  assign start_seen = scl_in && scl_q && sda_q && !sda_in;
  assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise = scl_in && !scl_q;
  assign hit_ev = snif_act && scl_rise && snif_cnt == 3'h7
                  && !own_address_reg.format_select && bus_unit_enable
                  && snif_sh == own_address_reg.slave_addr;

  // Halving toggle and quarter counter.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      half_tgl <= 1'b0;
      qcnt <= 16'h0000;
    end else begin
      half_tgl <= !half_tgl;
      if (!run || qdone) begin
        qcnt <= 16'h0000;
      end else if (tick && !stretch) begin
        qcnt <= qcnt + 16'h0001;
      end
    end
  end

  // Line history, bus busy tracking and own-address sniffing.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_busy_flag <= 1'b0;
      snif_act <= 1'b0;
      snif_cnt <= 3'h0;
      snif_sh <= 7'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_seen) begin
        bus_busy_flag <= 1'b1;
      end else if (stop_seen) begin
        bus_busy_flag <= 1'b0;
      end
      if (start_seen) begin
        snif_act <= 1'b1;
        snif_cnt <= 3'h0;
      end else if (snif_act && scl_rise) begin
        snif_sh <= {snif_sh[5:0], sda_in};
        snif_cnt <= snif_cnt + 3'h1;
        if (snif_cnt == 3'h7) begin
          snif_act <= 1'b0;
        end
      end
    end
  end

  // Software registers; a hardware event wins over a same-cycle clear.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      own_address_reg <= OWN_ADDR_RST;
      mode_reg <= MODE_RST;
      bus_unit_enable <= 1'b0;
      transfer_irq_enable <= 1'b0;
      slave_reply_bit <= 1'b0;
      own_hit <= 1'b0;
      peripheral_clock_halve <= 1'b0;
      register_window_select <= 1'b0;
      master_select <= 1'b0;
      transmit_select <= 1'b0;
      arb_lost <= 1'b0;
      transfer_done_flag <= 1'b0;
    end else begin
      if (wr_shared && bus_unit_enable) begin
        mode_reg <= reg_wdata;
      end else if (wr_shared) begin
        own_address_reg <= reg_wdata;
      end
      if (wr_ctrl) begin
        bus_unit_enable <= reg_wdata[CTRL_BUE];
        transfer_irq_enable <= reg_wdata[CTRL_IE];
      end
      if (ev_ack) begin
        slave_reply_bit <= ack_val;
      end else if (wr_ctrl) begin
        slave_reply_bit <= reg_wdata[CTRL_REPLY];
      end
      own_hit <= hit_ev || (own_hit && !(wr_ctrl && !reg_wdata[CTRL_HIT]));
      if (wr_sys) begin
        peripheral_clock_halve <= reg_wdata[SYS_HALVE];
        register_window_select <= reg_wdata[SYS_WIN];
      end
      if (ev_arb) begin
        master_select <= 1'b0;
        transmit_select <= 1'b0;
      end else if (wr_bus) begin
        master_select <= reg_wdata[BUS_MS];
        transmit_select <= reg_wdata[BUS_TS];
      end
      arb_lost <= ev_arb || (arb_lost && !(wr_bus && !reg_wdata[BUS_ARB]));
      transfer_done_flag <= ev_done || (transfer_done_flag
                            && !(wr_bus && !reg_wdata[BUS_DONE]));
    end
  end

  // The data register is frozen while a byte is on the wire.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_shift_reg <= DATA_RST;
    end else if (wr_data && !run) begin
      data_shift_reg <= reg_wdata;
    end
  end

  // Transfer sequencer driving the open-drain enables.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= ST_IDLE;
      ph <= PH_SETUP;
      bit_idx <= 3'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      ev_done <= 1'b0;
      ev_ack <= 1'b0;
      ack_val <= 1'b0;
      ev_arb <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_ack <= 1'b0;
      ev_arb <= 1'b0;
      if (!bus_unit_enable) begin
        // Disabling the unit frees a stuck bus at once.
        st <= ST_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (st)
          ST_IDLE: begin
            if (start_req) begin
              sda_oe <= 1'b1;
              ph <= PH_SETUP;
              st <= ST_START;
            end
          end
          ST_START: begin
            if (qdone) begin
              scl_oe <= 1'b1;
              st <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // The clock stays low until software acts.
            if (stop_req) begin
              sda_oe <= 1'b1;
              ph <= PH_SETUP;
              st <= ST_STOP;
            end else if (wr_data && !transfer_done_flag
                         && master_select && transmit_select) begin
              // Byte loads this cycle, so the first bit is taken directly.
              sda_oe <= mode_reg.bit_order_select ? !reg_wdata[0]
                                                  : !reg_wdata[7];
              bit_idx <= 3'h0;
              ph <= PH_SETUP;
              st <= ST_BIT;
            end
          end
          ST_BIT: begin
            if (qdone) begin
              case (ph)
                PH_SETUP: begin
                  scl_oe <= 1'b0;
                  ph <= PH_RISE;
                end
                PH_RISE: begin
                  if (!sda_oe && !sda_in) begin
                    // Another master pulled a released line low.
                    scl_oe <= 1'b0;
                    ev_arb <= 1'b1;
                    ev_done <= 1'b1;
                    st <= ST_IDLE;
                  end else begin
                    ph <= PH_HIGH;
                  end
                end
                PH_HIGH: begin
                  scl_oe <= 1'b1;
                  ph <= PH_FALL;
                end
                PH_FALL: begin
                  ph <= PH_SETUP;
                  if (bit_idx != 3'h7) begin
                    bit_idx <= bit_idx + 3'h1;
                    sda_oe <= !pick_bit(3'(bit_idx + 3'h1));
                  end else if (mode_reg.pause_insert) begin
                    sda_oe <= 1'b0;
                    st <= ST_PAUSE;
                  end else if (!mode_reg.reply_check_off) begin
                    sda_oe <= 1'b0;
                    st <= ST_ACK;
                  end else begin
                    sda_oe <= 1'b0;
                    ev_done <= 1'b1;
                    st <= ST_HOLD;
                  end
                end
                default: ph <= PH_SETUP;
              endcase
            end
          end
          ST_PAUSE: begin
            // One full bit time with the clock held low.
            if (qdone) begin
              ph <= ph + 2'h1;
              if (ph == PH_FALL) begin
                if (!mode_reg.reply_check_off) begin
                  st <= ST_ACK;
                end else begin
                  ev_done <= 1'b1;
                  st <= ST_HOLD;
                end
              end
            end
          end
          ST_ACK: begin
            if (qdone) begin
              case (ph)
                PH_SETUP: begin
                  scl_oe <= 1'b0;
                  ph <= PH_RISE;
                end
                PH_RISE: begin
                  ev_ack <= 1'b1;
                  ack_val <= sda_in;
                  ph <= PH_HIGH;
                end
                PH_HIGH: begin
                  scl_oe <= 1'b1;
                  ph <= PH_FALL;
                end
                PH_FALL: begin
                  ev_done <= 1'b1;
                  ph <= PH_SETUP;
                  st <= ST_HOLD;
                end
                default: ph <= PH_SETUP;
              endcase
            end
          end
          ST_STOP: begin
            if (qdone) begin
              if (ph == PH_SETUP) begin
                scl_oe <= 1'b0;
                ph <= PH_RISE;
              end else begin
                sda_oe <= 1'b0;
                st <= ST_IDLE;
              end
            end
          end
          default: begin
            st <= ST_IDLE;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read multiplexer; closed window and unmapped addresses read zero.
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_SHARED: begin
        if (register_window_select) begin
          rd_mux = bus_unit_enable ? mode_reg : own_address_reg;
        end
      end
      ADDR_CTRL: begin
        if (register_window_select) begin
          rd_mux[CTRL_BUE] = bus_unit_enable;
          rd_mux[CTRL_IE] = transfer_irq_enable;
          rd_mux[CTRL_REPLY] = slave_reply_bit;
          rd_mux[CTRL_HIT] = own_hit;
        end
      end
      ADDR_BUS: begin
        if (register_window_select) begin
          rd_mux[BUS_BUSY] = bus_busy_flag;
          rd_mux[BUS_GATE] = 1'b1;
          rd_mux[BUS_MS] = master_select;
          rd_mux[BUS_TS] = transmit_select;
          rd_mux[BUS_ARB] = arb_lost;
          rd_mux[BUS_DONE] = transfer_done_flag;
        end
      end
      ADDR_DATA: begin
        if (register_window_select) begin
          rd_mux = data_shift_reg;
        end
      end
      ADDR_SYS: begin
        rd_mux[SYS_HALVE] = peripheral_clock_halve;
        rd_mux[SYS_WIN] = register_window_select;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stand for one cycle; pins only ever pull low.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      irq_req <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      irq_req <= transfer_done_flag && transfer_irq_enable;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_irq_from_flag: assert property (
    ##1 irq_req == $past(transfer_done_flag && transfer_irq_enable))
    else $error("interrupt request does not follow done and enable");

  chk_start_shape: assert property (
    $rose(st == ST_START) |-> sda_oe && !scl_oe && !$past(sda_oe))
    else $error("start did not pull SDA low with SCL high");

  chk_stop_shape: assert property (
    (st == ST_STOP && bus_unit_enable ##1 st == ST_IDLE)
      |-> !sda_oe && !scl_oe && $past(sda_oe) && !$past(scl_oe))
    else $error("stop did not release SDA with SCL high");

  chk_scl_held: assert property (
    st == ST_HOLD |-> scl_oe)
    else $error("SCL not held low while waiting");

  chk_msb_first: assert property (
    (st == ST_BIT && ph == PH_RISE && !mode_reg.bit_order_select)
      |-> sda_oe == !data_shift_reg[3'h7 - bit_idx])
    else $error("data bit out of order");

  chk_no_pause: assert property (
    (st == ST_BIT && ph == PH_FALL && qdone && bit_idx == 3'h7
     && !mode_reg.pause_insert && !mode_reg.reply_check_off
     && bus_unit_enable) |=> st == ST_ACK)
    else $error("acknowledge did not follow the eighth bit");

  chk_ack_record: assert property (
    (st == ST_ACK && ph == PH_RISE && qdone && bus_unit_enable)
      |-> ##2 slave_reply_bit == $past(sda_in, 2))
    else $error("acknowledge not recorded");

  chk_done_ninth: assert property (
    (st == ST_ACK && ph == PH_FALL && qdone && bus_unit_enable)
      |-> ##2 transfer_done_flag)
    else $error("done flag not set after ninth clock");

  chk_shared_read: assert property (
    (reg_rd && reg_addr == ADDR_SHARED && register_window_select
     && bus_unit_enable) |=> reg_rdata == $past(mode_reg))
    else $error("shared address did not read the mode register");

  chk_busy_start: assert property (
    start_seen |=> bus_busy_flag)
    else $error("busy flag missed a start condition");

  chk_halve_tick: assert property (
    (peripheral_clock_halve && $past(peripheral_clock_halve))
      |-> !(tick && $past(tick)))
    else $error("halved clock ticked twice in a row");

  cov_byte_done: cover property ($rose(transfer_done_flag) && !arb_lost);
  cov_stop_sent: cover property (st == ST_STOP ##1 st == ST_IDLE);
  cov_arb_lost: cover property ($rose(arb_lost));
  cov_own_hit: cover property ($rose(own_hit));

endmodule // imt_master_tx

`default_nettype wire

// file: imt_slave_model.sv
// Behavioural bus slave that acknowledges its address and later bytes.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module imt_slave_model (
  // Bus lines.
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  // Test controls and captured bytes.
  input wire logic [6:0] slv_addr,
  input wire logic nack,
  input wire logic stretch,
  output logic [7:0] rx_byte,
  output logic rx_tgl
);
  int bitn = 10;
  logic [7:0] sh = 8'h00;
  logic hit = 1'b0;
  logic first = 1'b0;

  // Lines start released.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    rx_tgl = 1'b0;
  end

  // A start restarts the bit count; a stop parks it.
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = 0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl === 1'b1) bitn = 10;

  // Bits are taken on the rising clock edge, first bit into the top.
  always @(posedge scl) if (bitn < 8) begin
    sh = {sh[6:0], sda};
    bitn++;
  end

  // Ack holds through the ninth clock; stretching makes the master wait.
  always @(negedge scl) begin
    if (bitn == 8) begin
      rx_byte = sh;
      rx_tgl = ~rx_tgl;
      if (first) hit = (sh == {slv_addr, 1'b0});
      first = 1'b0;
      sda_oe = hit && !nack;
      bitn = 9;
      if (stretch) begin
        scl_oe = 1'b1;
        #200 scl_oe = 1'b0;
      end
    end else if (bitn == 9) begin
      sda_oe = 1'b0;
      bitn = 0;
    end
  end
endmodule // imt_slave_model

`default_nettype wire

// file: testbench.sv
// Self-checking bench: register traffic, three bytes and a stop.
// Assumes the slave model and short quarter timing in simulation.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  err_total++; $display("mismatch %0t got %h exp %h", $time, got, exp); \
  end end

module testbench import imt_pkg::*;;
  logic clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_byte, own, d2, d3, e;
  logic [6:0] slv;
  logic scl_oe, sda_oe, scl_oe_s, sda_oe_s, irq_req, rx_tgl, scl_o, sda_o;
  logic nack = 0, stretch = 0;
  // Pull-ups win unless a side drives; the master drives its output value.
  wire logic scl = !scl_oe_s && (scl_oe ? scl_o : 1'b1);
  wire logic sda = !sda_oe_s && (sda_oe ? sda_o : 1'b1);
  int err_total = 0, cmp_count = 0, n_start = 0, n_stop = 0;
  logic [7:0] exp_q[$], byte_q[$];

  imt_master_tx #(.QTR_CYCLES(3)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_o),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe),
    .irq_req(irq_req));
  imt_slave_model slave (.scl(scl), .sda(sda), .scl_oe(scl_oe_s),
    .sda_oe(sda_oe_s), .slv_addr(slv), .nack(nack), .stretch(stretch),
    .rx_byte(rx_byte), .rx_tgl(rx_tgl));

  // The 100 MHz system clock.
  always #5 clk_sys = ~clk_sys;

  // Count line conditions; gated by reset to skip time-zero settling.
  always @(negedge sda) if (scl === 1'b1 && nrst) n_start++;
  always @(posedge sda) if (scl === 1'b1 && nrst) n_stop++;

  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys) begin
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    rd_d <= reg_rd;
  end

  // Every byte seen by the slave is held against the written one, bit-reversed where it went out least significant bit first.
  always @(rx_tgl) if (byte_q.size() > 0) begin
    e = byte_q.pop_front();
    `CHK(rx_byte, e)
  end

  // One access; strobes stay up so back-to-back calls never clash.
  task automatic acc(input bit w, input logic [2:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask

  function automatic bit cond(input int w);
    return (w == 0) ? irq_req : (w == 1) ? !scl : (w == 2) ? (n_stop > 0)
      : !irq_req;
  endfunction

  // Bit reversal for the byte a least-significant-first master sends.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[3'(7 - i)];
  endfunction

  // Drop strobes, then wait a bounded time for a condition.
  task automatic wt(input int w);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    for (int n = 0; n < 3000 && !cond(w); n++) @(posedge clk_sys);
    if (!cond(w)) begin
      err_total++;
      $display("mismatch %0t wait %0d timed out", $time, w);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog sized well past the expected run.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    conclude();
  end

  // Main sequence.
  initial begin
    void'($urandom(93));
    own = {7'($urandom_range(127, 1)), 1'b0};
    slv = own[7:1] ^ 7'h2a;
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    acc(0, ADDR_SYS, 8'h00);
    acc(0, ADDR_SHARED, 8'h00);
    acc(0, 3'h5, 8'h00);
    acc(0, ADDR_BUS, 8'h00);
    acc(1, ADDR_SYS, 8'h02);
    acc(0, ADDR_SYS, 8'h02);
    acc(0, ADDR_BUS, 8'h40);
    acc(1, ADDR_SHARED, own);
    acc(0, ADDR_SHARED, own);
    acc(1, ADDR_CTRL, 8'hc0);
    acc(1, ADDR_SHARED, 8'h00);
    acc(0, ADDR_SHARED, 8'h00);
    acc(1, ADDR_BUS, 8'hb0);
    wt(1);
    acc(0, ADDR_BUS, 8'hf0);
    `CHK(n_start, 1)
    stretch <= 1'b1;
    byte_q.push_back({slv, 1'b0});
    acc(1, ADDR_DATA, {slv, 1'b0});
    wt(0);
    `CHK(irq_req, 1'b1)
    `CHK(scl, 1'b0)
    acc(0, ADDR_BUS, 8'hf1);
    acc(0, ADDR_CTRL, 8'hc0);
    acc(1, ADDR_BUS, 8'h70);
    acc(1, ADDR_SYS, 8'h03);
    acc(0, ADDR_SYS, 8'h03);
    wt(3);
    `CHK(irq_req, 1'b0)
    stretch <= 1'b0;
    nack <= 1'b1;
    byte_q.push_back(d2);
    acc(1, ADDR_DATA, d2);
    wt(0);
    acc(0, ADDR_CTRL, 8'hc8);
    acc(1, ADDR_BUS, 8'h70);
    acc(1, ADDR_SHARED, 8'he0);
    acc(0, ADDR_SHARED, 8'he0);
    wt(3);
    byte_q.push_back(rev8(d3));
    acc(1, ADDR_DATA, d3);
    wt(0);
    `CHK(scl, 1'b0)
    acc(1, ADDR_BUS, 8'h30);
    wt(2);
    repeat (3) @(posedge clk_sys);
    acc(0, ADDR_BUS, 8'h70);
    wt(2);
    repeat (2) @(posedge clk_sys);
    `CHK(n_stop, 1)
    `CHK(sda, 1'b1)
    `CHK(byte_q.size(), 0)
    conclude();
  end
endmodule // testbench

`default_nettype wire
